// ---- pkg/sce_defs.vh ----
`ifndef SCE_DEFS_VH
`define SCE_DEFS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define SCE_OFS_MODE      12'h200
`define SCE_OFS_MASK      12'h204
`define SCE_OFS_CMD       12'h208
`define SCE_OFS_FLAGS     12'h20c
`define SCE_OFS_STATE     12'h210
`define SCE_OFS_WRSIZE    12'h214
`define SCE_OFS_FREE      12'h218
`define SCE_OFS_KAIVL     12'h21c
`define SCE_OFS_MSS       12'h220
`define SCE_OFS_DHAR_LO   12'h224
`define SCE_OFS_DHAR_HI   12'h228
`define SCE_OFS_GIRQ      12'h22c
`define SCE_OFS_GMASK     12'h230

// ****************************************
// Reset values
// ****************************************
`define SCE_RST_MASK      8'hff
`define SCE_RST_MSS       16'h05b4

// ****************************************
// Command codes
// ****************************************
`define SCE_CMD_TEARDOWN  8'h08
`define SCE_CMD_CLOSE     8'h10
`define SCE_CMD_SEND      8'h20
`define SCE_CMD_DSEND     8'h21
`define SCE_CMD_KEEP      8'h22
`define SCE_CMD_PPP_OPEN  8'h23
`define SCE_CMD_PPP_REJ   8'h27
`define SCE_CMD_RXACK     8'h40

// ****************************************
// Protocol modes and socket states
// ****************************************
`define SCE_MODE_TCP      4'h1
`define SCE_MODE_UDP      4'h2
`define SCE_MODE_RAW_IP_MODE    4'h3
`define SCE_MODE_RAW_ETHERNET_MODE   4'h4
`define SCE_MODE_PPPOE    4'h5
`define SCE_ST_CLOSED     8'h00
`define SCE_ST_CONNECTED  8'h17

// ****************************************
// Event flag bit positions
// ****************************************
`define SCE_FLG_LINK_UP   0
`define SCE_FLG_TEARDOWN_CMD    1
`define SCE_FLG_RECEIVE_ACK_CMD      2
`define SCE_FLG_TIMEOUT   3
`define SCE_FLG_SEND_DONE 4
`define SCE_FLG_PPP_PHASE 5
`define SCE_FLG_PPP_FAIL  6
`define SCE_FLG_PPP_OPT   7

// ****************************************
// Outgoing packet kinds
// ****************************************
`define SCE_PKT_DATA      2'h0
`define SCE_PKT_FIN       2'h1
`define SCE_PKT_KA        2'h2
`define SCE_PKT_ARP       2'h3

`endif

// ---- verilog/sce_socket_command_engine.v ----
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "sce_defs.vh"
module sce_socket_command_engine #(
    parameter [2:0] SOCK_ID        = 3'h0,
    parameter       RTO_CYCLES     = 20000,
    parameter       KA_TICK_CYCLES = 125000,
    parameter       TX_MEM_BYTES   = 8192
) (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Packet transmit request
    output wire        pkt_valid,
    output wire [1:0]  pkt_kind,
    output reg  [16:0] pkt_len,
    output reg         pkt_use_dhar,
    output wire [47:0] dest_hw_address,
    input  wire        pkt_taken,
    // Peer and link events
    input  wire        peer_fin,
    input  wire        peer_finack,
    input  wire        peer_rst,
    input  wire        peer_ack,
    input  wire        peer_data,
    input  wire        arp_reply,
    input  wire        link_up,
    input  wire        ppp_phase,
    input  wire        ppp_auth_fail,
    input  wire        ppp_option,
    // Connection logic outside this block
    input  wire        state_load,
    input  wire [7:0]  state_load_val,
    // Receive and PPPoE sideband
    output reg         rx_consumed,
    output reg         ppp_cmd_valid,
    output reg  [7:0]  ppp_cmd_code,
    // Interrupt
    output wire        irq_n
);

// ****************************************
// States
// ****************************************
localparam [3:0] S_IDLE = 4'h0;
localparam [3:0] S_ARP  = 4'h1;
localparam [3:0] S_ARPW = 4'h2;
localparam [3:0] S_SEG  = 4'h3;
localparam [3:0] S_ACK  = 4'h4;
localparam [3:0] S_FIN  = 4'h5;
localparam [3:0] S_FINW = 4'h6;
localparam [3:0] S_KA   = 4'h7;
localparam [3:0] S_KAW  = 4'h8;

reg  [3:0]  fsm_r;
reg  [3:0]  mode_r;
reg  [7:0]  mask_r;
reg  [7:0]  flags_r;
reg  [7:0]  flags_nxt;
reg  [7:0]  state_r;
reg  [16:0] wrsize_r;
reg  [16:0] free_r;
reg  [16:0] remain_r;
reg  [7:0]  kaivl_r;
reg  [15:0] mss_r;
reg  [47:0] dhar_r;
reg         gmask_r;
reg  [31:0] tmo_cnt_r;
reg  [31:0] tick_cnt_r;
reg  [7:0]  idle_ticks_r;
reg         data_seen_r;
reg  [7:0]  ev;
reg         fail;
reg         send_ok;

wire        wr_acc   = psel & penable & pwrite;
wire        rd_setup = psel & ~penable & ~pwrite;
wire        is_tcp   = (mode_r == `SCE_MODE_TCP);
wire        is_udp   = (mode_r == `SCE_MODE_UDP);
wire        is_raw   = (mode_r == `SCE_MODE_RAW_IP_MODE) | (mode_r == `SCE_MODE_RAW_ETHERNET_MODE);
wire        conn     = (state_r == `SCE_ST_CONNECTED);
wire        cmd_wr   = wr_acc & (paddr == `SCE_OFS_CMD);
wire [7:0]  cmd      = pwdata[7:0];
wire        tmo_hit  = (tmo_cnt_r == RTO_CYCLES - 1);
wire        tick     = (tick_cnt_r == KA_TICK_CYCLES - 1);
wire        girq     = |(flags_r & mask_r);
wire [16:0] seg_len  = ((is_tcp | is_udp) && (remain_r > {1'b0, mss_r})) ?
                       {1'b0, mss_r} : remain_r;
wire [16:0] start_len = ((is_tcp | is_udp) && (wrsize_r > {1'b0, mss_r})) ?
                       {1'b0, mss_r} : wrsize_r;
wire [16:0] nxt_len   = ((remain_r - seg_len) > {1'b0, mss_r}) ?
                       {1'b0, mss_r} : remain_r - seg_len;
wire        ka_due   = (kaivl_r != 8'h00) && (idle_ticks_r >= kaivl_r)
                       && data_seen_r && conn && is_tcp;
wire        mapped   = (paddr == `SCE_OFS_MODE) | (paddr == `SCE_OFS_MASK) |
                       (paddr == `SCE_OFS_CMD) | (paddr == `SCE_OFS_FLAGS) |
                       (paddr == `SCE_OFS_STATE) | (paddr == `SCE_OFS_WRSIZE) |
                       (paddr == `SCE_OFS_FREE) | (paddr == `SCE_OFS_KAIVL) |
                       (paddr == `SCE_OFS_MSS) | (paddr == `SCE_OFS_DHAR_LO) |
                       (paddr == `SCE_OFS_DHAR_HI) | (paddr == `SCE_OFS_GIRQ) |
                       (paddr == `SCE_OFS_GMASK);

assign pready          = 1'b1;
assign pslverr         = psel & penable & ~mapped;
assign dest_hw_address = dhar_r;
assign irq_n           = ~(girq & gmask_r);
assign pkt_valid       = (fsm_r == S_ARP) | (fsm_r == S_SEG) | (fsm_r == S_FIN)
                         | (fsm_r == S_KA);
assign pkt_kind        = (fsm_r == S_ARP) ? `SCE_PKT_ARP :
                         (fsm_r == S_FIN) ? `SCE_PKT_FIN :
                         (fsm_r == S_KA)  ? `SCE_PKT_KA  : `SCE_PKT_DATA;

// ****************************************
// Event flags
// ****************************************
// A hardware set in the same cycle as a write-one clear wins.
always @* begin
    ev = 8'h00;
    ev[`SCE_FLG_LINK_UP]   = link_up;
    ev[`SCE_FLG_TEARDOWN_CMD]    = peer_fin | peer_finack;
    ev[`SCE_FLG_RECEIVE_ACK_CMD]      = peer_data;
    ev[`SCE_FLG_TIMEOUT]   = fail;
    ev[`SCE_FLG_SEND_DONE] = send_ok;
    ev[`SCE_FLG_PPP_PHASE] = ppp_phase;
    ev[`SCE_FLG_PPP_FAIL]  = ppp_auth_fail;
    ev[`SCE_FLG_PPP_OPT]   = ppp_option;
    flags_nxt = flags_r;
    if (wr_acc && (paddr == `SCE_OFS_FLAGS)) begin
        flags_nxt = flags_nxt & ~pwdata[7:0];
    end
    flags_nxt = flags_nxt | (ev & mask_r);
end

always @* begin
    fail = 1'b0;
    send_ok = 1'b0;
    if (!peer_rst && tmo_hit && ((fsm_r == S_ARPW) || (fsm_r == S_ACK) ||
        (fsm_r == S_FINW) || (fsm_r == S_KAW))) begin
        fail = 1'b1;
    end
    if (!peer_rst && !fail) begin
        if ((fsm_r == S_ACK) && peer_ack && (remain_r == 17'h00000)) begin
            send_ok = 1'b1;
        end
        if ((fsm_r == S_SEG) && pkt_taken && !is_tcp && (remain_r == seg_len)) begin
            send_ok = 1'b1;
        end
    end
end

// ****************************************
// Register file and command engine
// ****************************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        fsm_r         <= S_IDLE;
        mode_r        <= 4'h0;
        mask_r        <= `SCE_RST_MASK;
        flags_r       <= 8'h00;
        state_r       <= `SCE_ST_CLOSED;
        wrsize_r      <= 17'h00000;
        free_r        <= TX_MEM_BYTES[16:0];
        remain_r      <= 17'h00000;
        kaivl_r       <= 8'h00;
        mss_r         <= `SCE_RST_MSS;
        dhar_r        <= 48'h000000000000;
        gmask_r       <= 1'b0;
        tmo_cnt_r     <= 32'h00000000;
        tick_cnt_r    <= 32'h00000000;
        idle_ticks_r  <= 8'h00;
        data_seen_r   <= 1'b0;
        prdata        <= 32'h00000000;
        pkt_len       <= 17'h00000;
        pkt_use_dhar  <= 1'b0;
        rx_consumed   <= 1'b0;
        ppp_cmd_valid <= 1'b0;
        ppp_cmd_code  <= 8'h00;
    end else begin
        flags_r       <= flags_nxt;
        rx_consumed   <= 1'b0;
        ppp_cmd_valid <= 1'b0;
        if ((fsm_r != S_ACK) || peer_ack) begin
            pkt_len <= seg_len;
        end
        if (rd_setup) begin
            case (paddr)
                `SCE_OFS_MODE:    prdata <= {28'h0000000, mode_r};
                `SCE_OFS_MASK:    prdata <= {24'h000000, mask_r};
                `SCE_OFS_FLAGS:   prdata <= {24'h000000, flags_r};
                `SCE_OFS_STATE:   prdata <= {24'h000000, state_r};
                `SCE_OFS_WRSIZE:  prdata <= {15'h0000, wrsize_r};
                `SCE_OFS_FREE:    prdata <= {15'h0000, free_r};
                `SCE_OFS_KAIVL:   prdata <= {24'h000000, kaivl_r};
                `SCE_OFS_MSS:     prdata <= {16'h0000, mss_r};
                `SCE_OFS_DHAR_LO: prdata <= dhar_r[31:0];
                `SCE_OFS_DHAR_HI: prdata <= {16'h0000, dhar_r[47:32]};
                `SCE_OFS_GIRQ:    prdata <= {24'h000000, 8'h01 << SOCK_ID}
                                            & {32{girq}};
                `SCE_OFS_GMASK:   prdata <= {31'h00000000, gmask_r};
                default:          prdata <= 32'h00000000;
            endcase
        end
        if (wr_acc) begin
            case (paddr)
                `SCE_OFS_MODE:    mode_r <= pwdata[3:0];
                `SCE_OFS_MASK:    mask_r <= pwdata[7:0];
                `SCE_OFS_WRSIZE:  wrsize_r <= pwdata[16:0];
                `SCE_OFS_KAIVL:   kaivl_r <= pwdata[7:0];
                `SCE_OFS_MSS:     mss_r <= pwdata[15:0];
                `SCE_OFS_DHAR_LO: dhar_r[31:0] <= pwdata;
                `SCE_OFS_DHAR_HI: dhar_r[47:32] <= pwdata[15:0];
                `SCE_OFS_GMASK:   gmask_r <= pwdata[0];
                default:          gmask_r <= gmask_r;
            endcase
        end
        // Keep-alive silence timer; the prescaler keeps the counter narrow.
        tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
        if (peer_data || peer_ack || !conn || (fsm_r != S_IDLE)) begin
            idle_ticks_r <= 8'h00;
        end else if (tick && (idle_ticks_r != 8'hff)) begin
            idle_ticks_r <= idle_ticks_r + 8'h01;
        end
        if (peer_data || (peer_ack && (fsm_r == S_ACK))) begin
            data_seen_r <= 1'b1;
        end
        if (state_load) begin
            state_r <= state_load_val;
            data_seen_r <= 1'b0;
        end
        tmo_cnt_r <= 32'h00000000;
        if (peer_rst) begin
            state_r <= `SCE_ST_CLOSED;
            fsm_r   <= S_IDLE;
        end else if (fail) begin
            state_r <= `SCE_ST_CLOSED;
            fsm_r   <= S_IDLE;
        end else begin
            case (fsm_r)
                S_IDLE: begin
                    if (cmd_wr && (cmd == `SCE_CMD_CLOSE)) begin
                        state_r <= `SCE_ST_CLOSED;
                    end else if (cmd_wr && (cmd == `SCE_CMD_TEARDOWN)) begin
                        if (is_tcp && conn) begin
                            fsm_r <= S_FIN;
                        end
                    end else if (cmd_wr && ((cmd == `SCE_CMD_SEND) ||
                                 (cmd == `SCE_CMD_DSEND))) begin
                        // Direct send only exists for UDP and raw IP.
                        if ((cmd == `SCE_CMD_SEND) && (is_tcp ? conn : (is_udp || is_raw))
                            || (cmd == `SCE_CMD_DSEND) &&
                               (is_udp || (mode_r == `SCE_MODE_RAW_IP_MODE))) begin
                            remain_r     <= wrsize_r;
                            pkt_len      <= start_len;
                            pkt_use_dhar <= (cmd == `SCE_CMD_DSEND);
                            if (is_tcp) begin
                                free_r <= free_r - wrsize_r;
                            end
                            if ((cmd == `SCE_CMD_SEND) &&
                                (is_udp || (mode_r == `SCE_MODE_RAW_IP_MODE))) begin
                                fsm_r <= S_ARP;
                            end else begin
                                fsm_r <= S_SEG;
                            end
                        end
                    end else if (cmd_wr && (cmd == `SCE_CMD_KEEP)) begin
                        if (is_tcp && conn && (kaivl_r == 8'h00) && data_seen_r) begin
                            fsm_r <= S_KA;
                        end
                    end else if (cmd_wr && (cmd == `SCE_CMD_RXACK)) begin
                        rx_consumed <= (state_r != `SCE_ST_CLOSED);
                    end else if (cmd_wr && (cmd >= `SCE_CMD_PPP_OPEN) &&
                                 (cmd <= `SCE_CMD_PPP_REJ)) begin
                        if ((SOCK_ID == 3'h0) && (mode_r == `SCE_MODE_PPPOE)) begin
                            ppp_cmd_valid <= 1'b1;
                            ppp_cmd_code  <= cmd;
                        end
                    end else if (peer_fin && is_tcp && conn) begin
                        fsm_r <= S_FIN;
                    end else if (ka_due) begin
                        fsm_r <= S_KA;
                    end
                end
                S_ARP: begin
                    if (pkt_taken) begin
                        fsm_r <= S_ARPW;
                    end
                end
                S_ARPW: begin
                    tmo_cnt_r <= tmo_cnt_r + 32'h00000001;
                    if (arp_reply) begin
                        fsm_r <= S_SEG;
                    end
                end
                S_SEG: begin
                    if (pkt_taken) begin
                        remain_r <= remain_r - seg_len;
                        if (is_tcp) begin
                            fsm_r <= S_ACK;
                        end else if (remain_r == seg_len) begin
                            fsm_r <= S_IDLE;
                        end else begin
                            pkt_len <= nxt_len;
                        end
                    end
                end
                S_ACK: begin
                    tmo_cnt_r <= tmo_cnt_r + 32'h00000001;
                    if (peer_ack) begin
                        free_r <= free_r + pkt_len;
                        fsm_r  <= (remain_r == 17'h00000) ? S_IDLE : S_SEG;
                    end
                end
                S_FIN: begin
                    if (pkt_taken) begin
                        fsm_r <= S_FINW;
                    end
                end
                S_FINW: begin
                    tmo_cnt_r <= tmo_cnt_r + 32'h00000001;
                    if (peer_finack) begin
                        state_r <= `SCE_ST_CLOSED;
                        fsm_r   <= S_IDLE;
                    end
                end
                S_KA: begin
                    if (pkt_taken) begin
                        fsm_r <= S_KAW;
                    end
                end
                S_KAW: begin
                    tmo_cnt_r <= tmo_cnt_r + 32'h00000001;
                    if (peer_ack) begin
                        fsm_r <= S_IDLE;
                    end
                end
                default: fsm_r <= S_IDLE;
            endcase
        end
    end
end

endmodule // sce_socket_command_engine

// ---- sim/sce_peer.sv ----
`timescale 1ns/10ps
// ****************
// Remote peer
// ****************
module sce_peer (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Packet link
    input  wire        pkt_valid,
    input  wire [1:0]  pkt_kind,
    input  wire [16:0] pkt_len,
    output reg         pkt_taken,
    // Answer control
    input  wire        ans,
    input  wire        tcp,
    input  wire [3:0]  dly,
    output reg         ack,
    output reg         finack,
    output reg         arp,
    // One count byte per packet kind
    output reg  [31:0] cnt,
    output reg  [31:0] bytes
);
    reg [3:0] wait_r;
    reg [1:0] kind_r;
    reg       resp_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_taken <= 1'b0;
            ack       <= 1'b0;
            finack    <= 1'b0;
            arp       <= 1'b0;
            cnt       <= 32'h0;
            bytes     <= 32'h0;
            wait_r    <= 4'h0;
            kind_r    <= 2'h0;
            resp_r    <= 1'b0;
        end else begin
            pkt_taken <= 1'b0;
            ack       <= pkt_taken && resp_r && (kind_r == 2'h2 || (kind_r == 2'h0 && tcp));
            finack    <= pkt_taken && resp_r && kind_r == 2'h1;
            arp       <= pkt_taken && resp_r && kind_r == 2'h3;
            if (pkt_valid && !pkt_taken) begin
                if (wait_r == dly) begin
                    pkt_taken <= 1'b1;
                    wait_r    <= 4'h0;
                    kind_r    <= pkt_kind;
                    resp_r    <= ans;
                    cnt       <= cnt + (32'h1 << {pkt_kind, 3'h0});
                    bytes     <= bytes + (pkt_kind == 2'h0 ? {15'h0, pkt_len} : 32'h0);
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end
        end
    end
endmodule // sce_peer

// ---- sim/sce_chk_assertions.sv ----
`timescale 1ns/10ps
`include "sce_defs.vh"
// ****************
// Port checks
// ****************
module sce_chk (
    // APB
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pslverr,
    // Packet and sideband
    input wire        pkt_valid,
    input wire [1:0]  pkt_kind,
    input wire [16:0] pkt_len,
    input wire        pkt_use_dhar,
    input wire        pkt_taken,
    input wire        peer_rst,
    input wire        rx_consumed,
    input wire        ppp_cmd_valid,
    input wire [7:0]  ppp_cmd_code
);
    wire cmd_wr = psel && penable && pwrite && paddr == `SCE_OFS_CMD;
    wire rx_wr  = cmd_wr && pwdata[7:0] == `SCE_CMD_RXACK;
    wire ppp_wr = cmd_wr && pwdata[7:0] >= 8'h23 && pwdata[7:0] <= 8'h27;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_pkt_hold: assert property (
        pkt_valid && !pkt_taken && !peer_rst |=> pkt_valid && $stable(pkt_kind) && $stable(pkt_len))
        else $error("packet request changed before taken");
    chk_len_nonzero: assert property (
        pkt_valid && pkt_kind == `SCE_PKT_DATA |-> pkt_len != 17'h0)
        else $error("empty data piece");
    chk_dhar_no_arp: assert property (
        pkt_valid && pkt_use_dhar |-> pkt_kind != `SCE_PKT_ARP)
        else $error("address request on direct send");
    chk_slverr_phase: assert property (
        pslverr |-> psel && penable)
        else $error("error outside access phase");
    chk_slverr_data: assert property (
        pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_rx_cause: assert property (
        rx_consumed |-> $past(rx_wr) || $past(rx_wr, 2))
        else $error("receive release without command");
    chk_rx_pulse: assert property (
        rx_consumed |=> !rx_consumed)
        else $error("receive release longer than a cycle");
    chk_ppp_cause: assert property (
        ppp_cmd_valid |-> $past(ppp_wr) || $past(ppp_wr, 2))
        else $error("link command without host write");
    chk_ppp_code: assert property (
        ppp_cmd_valid |-> ppp_cmd_code >= 8'h23 && ppp_cmd_code <= 8'h27)
        else $error("link command code out of range");
    cover property (pkt_valid && pkt_taken && pkt_kind == `SCE_PKT_DATA);
    cover property (ppp_cmd_valid);
    cover property (pslverr);
endmodule // sce_chk

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`include "sce_defs.vh"
// ****************
// Bench
// ****************
module testbench;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h0;
    reg  [31:0] pwdata = 32'h0;
    reg  [7:0]  ev = 8'h0;
    reg  [7:0]  ld_val = 8'h0;
    reg         ans = 1'b1;
    reg         tcp = 1'b1;
    reg  [3:0]  dly = 4'h0;
    reg  [31:0] rd;
    reg         err;
    reg  [31:0] exp_cnt = 32'h0;
    integer     miscompares = 0;
    integer     comparisons = 0;
    integer     k;
    wire [31:0] prdata, cnt, bytes;
    wire [16:0] pkt_len;
    wire [1:0]  pkt_kind;
    wire        pready, pslverr, pkt_valid, pkt_taken, ack, finack, arp, irq_n;
    wire        ppp_v, rx_c;
    integer     ppp_n = 0, rx_n = 0;
    sce_socket_command_engine #(.RTO_CYCLES(50), .KA_TICK_CYCLES(10)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pkt_valid(pkt_valid), .pkt_kind(pkt_kind), .pkt_len(pkt_len), .pkt_use_dhar(),
        .dest_hw_address(), .pkt_taken(pkt_taken), .peer_fin(ev[0]), .peer_finack(finack),
        .peer_rst(ev[1]), .peer_ack(ack), .peer_data(ev[2]), .arp_reply(arp),
        .link_up(ev[3]), .ppp_phase(ev[4]), .ppp_auth_fail(ev[5]), .ppp_option(ev[6]),
        .state_load(ev[7]), .state_load_val(ld_val), .rx_consumed(rx_c), .ppp_cmd_valid(ppp_v),
        .ppp_cmd_code(), .irq_n(irq_n));
    sce_peer peer (.pclk(pclk), .presetn(presetn), .pkt_valid(pkt_valid), .pkt_kind(pkt_kind),
        .pkt_len(pkt_len), .pkt_taken(pkt_taken), .ans(ans), .tcp(tcp), .dly(dly), .ack(ack),
        .finack(finack), .arp(arp), .cnt(cnt), .bytes(bytes));
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        ppp_n <= ppp_n + ppp_v;
        rx_n  <= rx_n + rx_c;
    end
    task results;
        begin
            $display("comparisons %0d miscompares %0d", comparisons, miscompares);
            if (miscompares == 0 && comparisons > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    task tmo;
        begin
            miscompares = miscompares + 1;
            results;
        end
    endtask
    task chk(input [31:0] got, input [31:0] e);
        begin
            comparisons = comparisons + 1;
            if (got !== e) begin
                miscompares = miscompares + 1;
                $display("Error at %0t: got %h expected %h", $time, got, e);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer i;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            i = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && i < 16) begin
                @(posedge pclk);
                i = i + 1;
            end
            if (i == 16) tmo;
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rc(input [11:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd, e);
        end
    endtask
    task poll(input [11:0] a, input [31:0] m, input [31:0] e);
        integer i;
        begin
            i = 0;
            apb(1'b0, a, 32'h0);
            while ((rd & m) !== e && i < 200) begin
                apb(1'b0, a, 32'h0);
                i = i + 1;
            end
            chk(rd & m, e);
            if (i == 200) tmo;
        end
    endtask
    task wcnt;
        integer i;
        begin
            i = 0;
            while (cnt !== exp_cnt && i < 100) begin
                @(posedge pclk);
                i = i + 1;
            end
            chk(cnt, exp_cnt);
            if (i == 100) tmo;
        end
    endtask
    // The idle cycle keeps ev from two assignments in one step.
    task pulse(input [7:0] m);
        begin
            ev <= m;
            @(posedge pclk);
            ev <= 8'h0;
            @(posedge pclk);
        end
    endtask
    task connect;
        begin
            ld_val <= `SCE_ST_CONNECTED;
            pulse(8'h88);
            pulse(8'h04);
            rc(`SCE_OFS_STATE, 32'h17);
        end
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(`SCE_OFS_MASK, 32'hff);
        rc(`SCE_OFS_STATE, 32'h0);
        wr(`SCE_OFS_MASK, 32'hff00);
        rc(`SCE_OFS_MASK, 32'h0);
        wr(`SCE_OFS_MASK, 32'hff);
        apb(1'b0, 12'h300, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("test registers done");
        wr(`SCE_OFS_MODE, 32'h1);
        wr(`SCE_OFS_GMASK, 32'h1);
        connect;
        wr(`SCE_OFS_WRSIZE, 32'hbb8);
        wr(`SCE_OFS_CMD, 32'h20);
        poll(`SCE_OFS_FLAGS, 32'h10, 32'h10);
        exp_cnt = 32'h3;
        chk(cnt, exp_cnt);
        chk(bytes, 32'hbb8);
        rc(`SCE_OFS_FREE, 32'h2000);
        rc(`SCE_OFS_GIRQ, 32'h1);
        chk({31'h0, irq_n}, 32'h0);
        wr(`SCE_OFS_FLAGS, 32'hff);
        rc(`SCE_OFS_GIRQ, 32'h0);
        chk({31'h0, irq_n}, 32'h1);
        $display("test tcp send done");
        wr(`SCE_OFS_CMD, 32'h22);
        exp_cnt = exp_cnt + 32'h10000;
        wcnt;
        wr(`SCE_OFS_KAIVL, 32'h2);
        exp_cnt = exp_cnt + 32'h10000;
        wcnt;
        wr(`SCE_OFS_KAIVL, 32'h0);
        rc(`SCE_OFS_STATE, 32'h17);
        for (k = 0; k < 3; k = k + 1) begin
            connect;
            ans <= 1'b0;
            wr(`SCE_OFS_CMD, (k == 2) ? 32'h20 : k ? 32'h22 : 32'h08);
            poll(`SCE_OFS_FLAGS, 32'h8, 32'h8);
            rc(`SCE_OFS_STATE, 32'h0);
            ans <= 1'b1;
            wr(`SCE_OFS_FLAGS, 32'hff);
        end
        exp_cnt = exp_cnt + 32'h10101;
        connect;
        wr(`SCE_OFS_CMD, 32'h08);
        poll(`SCE_OFS_STATE, 32'hff, 32'h0);
        connect;
        pulse(8'h01);
        exp_cnt = exp_cnt + 32'h200;
        wcnt;
        poll(`SCE_OFS_STATE, 32'hff, 32'h0);
        connect;
        wr(`SCE_OFS_CMD, 32'h10);
        rc(`SCE_OFS_STATE, 32'h0);
        chk(cnt, exp_cnt);
        connect;
        pulse(8'h02);
        rc(`SCE_OFS_STATE, 32'h0);
        $display("test teardown done");
        wr(`SCE_OFS_MODE, 32'h2);
        tcp <= 1'b0;
        dly <= 4'h3;
        connect;
        for (k = 0; k < 2; k = k + 1) begin
            wr(`SCE_OFS_WRSIZE, 32'h64);
            wr(`SCE_OFS_CMD, k ? 32'h21 : 32'h20);
            poll(`SCE_OFS_FLAGS, 32'h10, 32'h10);
            wr(`SCE_OFS_FLAGS, 32'hff);
        end
        exp_cnt = exp_cnt + 32'h01000002;
        chk(cnt, exp_cnt);
        wr(`SCE_OFS_CMD, 32'h22);
        rc(`SCE_OFS_STATE, 32'h17);
        chk(cnt, exp_cnt);
        wr(`SCE_OFS_CMD, 32'h40);
        wr(`SCE_OFS_CMD, 32'h23);
        $display("test udp send done");
        wr(`SCE_OFS_MODE, 32'h5);
        for (k = 8'h23; k < 8'h28; k = k + 1)
            wr(`SCE_OFS_CMD, k);
        wr(`SCE_OFS_FLAGS, 32'hff);
        wr(`SCE_OFS_MASK, 32'h0);
        pulse(8'h70);
        rc(`SCE_OFS_FLAGS, 32'h0);
        wr(`SCE_OFS_MASK, 32'hff);
        pulse(8'h70);
        rc(`SCE_OFS_FLAGS, 32'he0);
        chk(ppp_n, 32'h5);
        chk(rx_n, 32'h1);
        $display("test link done");
        results;
    end
endmodule // testbench
bind sce_socket_command_engine sce_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_kind(pkt_kind), .pkt_len(pkt_len),
    .pkt_use_dhar(pkt_use_dhar), .pkt_taken(pkt_taken), .peer_rst(peer_rst),
    .rx_consumed(rx_consumed), .ppp_cmd_valid(ppp_cmd_valid), .ppp_cmd_code(ppp_cmd_code));
